// ==== rtl/sdcl_pkg.sv ====
package sdcl_pkg;
    // command bus widths
    localparam int ADDR_W = 12;
    localparam int BANK_BIT = 11;
    localparam int NUM_BANKS = 2;
    // clock period in ps and timing figures in ns
    localparam int CLK_PERIOD_PS = 5000;
    localparam int WRITE_TO_IDLE_TIME_NS = 30;
    localparam int MODE_SET_DELAY_NS = 10;
    localparam int REFRESH_CYCLE_TIME_NS = 60;
    localparam int BANK_TO_BANK_ACTIVATE_TIME_NS = 10;
    localparam int ACTIVE_TO_PRECHARGE_TIME_NS = 42;
    localparam int ACTIVATE_TO_COLUMN_TIME_NS = 15;
    // least times round up to whole cycles
    localparam int WRITE_TO_IDLE_CYC = (WRITE_TO_IDLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int MODE_SET_DELAY_CYC = (MODE_SET_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int REFRESH_CYCLE_CYC = (REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int BANK_TO_BANK_CYC = (BANK_TO_BANK_ACTIVATE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACTIVE_TO_PRECHARGE_CYC = (ACTIVE_TO_PRECHARGE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int ACTIVATE_TO_COLUMN_CYC = (ACTIVATE_TO_COLUMN_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TIMER_W = 4;
    // mode register fields
    localparam int BURST_LEN_LSB = 0;
    localparam int BURST_LEN_W = 3;
    localparam logic [2:0] BURST_FULL_PAGE = 3'h7;
    localparam logic [11:0] MODE_RESET_VAL = 12'h000;
    // command encodings: ras, cas, we with chip select low
    typedef enum logic [3:0] {
        SDCL_DESELECT_CMD, SDCL_NOP_CMD, SDCL_BURST_STOP_CMD, SDCL_READ_CMD,
        SDCL_WRITE_CMD, SDCL_ACTIVATE_CMD, SDCL_PRECHARGE_CMD, SDCL_REFRESH_CMD,
        SDCL_MODE_SET_CMD
    } sdcl_cmd_t;
    typedef enum logic [2:0] {
        SDCL_B_IDLE, SDCL_B_ACTIVE, SDCL_B_WRAP
    } sdcl_bank_t;
    typedef enum logic [2:0] {
        SDCL_D_NORMAL, SDCL_D_REFRESH, SDCL_D_MODE_SET, SDCL_D_POWER_DOWN, SDCL_D_SELF_REFRESH
    } sdcl_dev_t;
    // decode the four strobes into a command
    function automatic sdcl_cmd_t decode(input logic cs_n, input logic ras_n,
                                         input logic cas_n, input logic we_n);
        sdcl_cmd_t c;
        c = SDCL_DESELECT_CMD;
        if (!cs_n) begin
            unique case ({ras_n, cas_n, we_n})
                3'h7: c = SDCL_NOP_CMD;
                3'h6: c = SDCL_BURST_STOP_CMD;
                3'h5: c = SDCL_READ_CMD;
                3'h4: c = SDCL_WRITE_CMD;
                3'h3: c = SDCL_ACTIVATE_CMD;
                3'h2: c = SDCL_PRECHARGE_CMD;
                3'h1: c = SDCL_REFRESH_CMD;
                3'h0: c = SDCL_MODE_SET_CMD;
            endcase
        end
        return c;
    endfunction
endpackage

// ==== rtl/sdcl_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface sdcl_if;
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic [11:0] addr;
    modport device (input cs_n, ras_n, cas_n, we_n, cke, addr);
    modport host   (output cs_n, ras_n, cas_n, we_n, cke, addr);
endinterface
`default_nettype wire

// ==== rtl/sdcl_device.sv ====
`timescale 1ns/100ps
`default_nettype none
// Contract
// [RULE_01] write recovery autoprecharge: no-ops, idle after delay
// [RULE_02] host avoids commands to recovering bank
// [RULE_03] refresh: no-ops, idle after cycle time
// [RULE_04] mode set: no-ops until delay elapses
// [RULE_05] decode commands from four strobes
// [RULE_06] sample inputs on rising clock only
// [RULE_07] both banks idle before mode/refresh/powerdown
// [RULE_08] mode set loads address into mode register
// [RULE_09] refresh generates row internally, ignores address
// [RULE_10] self-refresh ignores all but clock enable
// [RULE_11] activate only idle bank
// [RULE_12] read/write only active bank
// [RULE_13] burst stop valid only in full page
// [RULE_14] cke low with banks idle: power-down
// [RULE_15] refresh with cke low: self-refresh
// [RULE_16] respect bank-to-bank activate interval
// [RULE_17] respect active-to-precharge interval
// [RULE_18] autoprecharge: precharged right after burst
// [RULE_19] wait activate-to-column delay before access
// [RULE_20] host tracks per-bank state and timers

module sdcl_device #(
    parameter int BURST_CYC = 4                  // burst beats before auto-precharge recovery
) (
    input  wire logic     clock,                 // system clock
    input  wire logic     rst_n,                 // async reset, active low
    sdcl_if.device        bus,                   // command pins
    output logic [11:0]   mode_q,                // loaded operating code
    output logic [10:0]   refresh_row_q,         // internal refresh row counter
    output logic [1:0]    bank_idle,             // per-bank idle
    output logic          dev_busy,              // refresh or mode set running
    output logic          power_down,            // in power-down
    output logic          self_refresh,          // in self-refresh
    output logic          illegal_q              // illegal command seen last cycle
);

    sdcl_pkg::sdcl_cmd_t  cmd;
    sdcl_pkg::sdcl_bank_t bank_q [2];
    sdcl_pkg::sdcl_dev_t  dev_q;
    logic [sdcl_pkg::TIMER_W-1:0] dev_tmr_q;
    logic [sdcl_pkg::TIMER_W-1:0] bank_tmr_q [2];
    logic        sel;
    logic        all_idle;
    logic        bad;
    logic        full_page;

    // strobes are read only at the clock edge through the registers below
    assign cmd       = sdcl_pkg::decode(bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n); // [RULE_05]
    assign sel       = bus.addr[sdcl_pkg::BANK_BIT];
    assign all_idle  = (bank_q[0] == sdcl_pkg::SDCL_B_IDLE) && (bank_q[1] == sdcl_pkg::SDCL_B_IDLE);
    assign full_page = mode_q[sdcl_pkg::BURST_LEN_LSB +: sdcl_pkg::BURST_LEN_W]
                       == sdcl_pkg::BURST_FULL_PAGE;

    // illegal command check; flagged only, the array itself does nothing
    always_comb begin
        bad = 1'b0;
        if (dev_q == sdcl_pkg::SDCL_D_REFRESH || dev_q == sdcl_pkg::SDCL_D_MODE_SET) begin
            bad = !(cmd inside {sdcl_pkg::SDCL_DESELECT_CMD, sdcl_pkg::SDCL_NOP_CMD,
                                sdcl_pkg::SDCL_BURST_STOP_CMD});           // [RULE_03] [RULE_04]
        end else if (dev_q == sdcl_pkg::SDCL_D_NORMAL && bus.cke) begin
            unique case (cmd)
                sdcl_pkg::SDCL_READ_CMD, sdcl_pkg::SDCL_WRITE_CMD:
                    bad = bank_q[sel] != sdcl_pkg::SDCL_B_ACTIVE;        // [RULE_12] [RULE_02]
                sdcl_pkg::SDCL_ACTIVATE_CMD:
                    bad = bank_q[sel] != sdcl_pkg::SDCL_B_IDLE;          // [RULE_11]
                sdcl_pkg::SDCL_PRECHARGE_CMD:
                    bad = bank_q[sel] == sdcl_pkg::SDCL_B_WRAP;          // [RULE_02]
                sdcl_pkg::SDCL_REFRESH_CMD, sdcl_pkg::SDCL_MODE_SET_CMD:
                    bad = !all_idle;                                     // [RULE_07]
                sdcl_pkg::SDCL_BURST_STOP_CMD:
                    bad = !full_page;                                    // [RULE_13]
                default: bad = 1'b0;
            endcase
        end
    end

    // device-wide state: refresh, mode set, power-down, self-refresh
    always_ff @(posedge clock or negedge rst_n) begin                    // [RULE_06]
        if (!rst_n) begin
            dev_q     <= sdcl_pkg::SDCL_D_NORMAL;
            dev_tmr_q <= '0;
        end else begin
            unique case (dev_q)
                sdcl_pkg::SDCL_D_NORMAL: begin
                    if (all_idle && !bus.cke && cmd == sdcl_pkg::SDCL_REFRESH_CMD) begin
                        dev_q <= sdcl_pkg::SDCL_D_SELF_REFRESH;          // [RULE_15]
                    end else if (all_idle && !bus.cke) begin
                        dev_q <= sdcl_pkg::SDCL_D_POWER_DOWN;            // [RULE_14]
                    end else if (bus.cke && !bad && cmd == sdcl_pkg::SDCL_REFRESH_CMD) begin
                        dev_q     <= sdcl_pkg::SDCL_D_REFRESH;
                        dev_tmr_q <= sdcl_pkg::TIMER_W'(sdcl_pkg::REFRESH_CYCLE_CYC - 1);
                    end else if (bus.cke && !bad && cmd == sdcl_pkg::SDCL_MODE_SET_CMD) begin
                        dev_q     <= sdcl_pkg::SDCL_D_MODE_SET;
                        dev_tmr_q <= sdcl_pkg::TIMER_W'(sdcl_pkg::MODE_SET_DELAY_CYC - 1);
                    end
                end
                sdcl_pkg::SDCL_D_REFRESH, sdcl_pkg::SDCL_D_MODE_SET: begin
                    // other commands are ignored here; timer alone ends the state
                    if (dev_tmr_q == '0) begin
                        dev_q <= sdcl_pkg::SDCL_D_NORMAL;                // [RULE_03] [RULE_04]
                    end else begin
                        dev_tmr_q <= dev_tmr_q - 1'b1;
                    end
                end
                sdcl_pkg::SDCL_D_POWER_DOWN: begin
                    if (bus.cke) begin
                        dev_q <= sdcl_pkg::SDCL_D_NORMAL;                // [RULE_14]
                    end
                end
                sdcl_pkg::SDCL_D_SELF_REFRESH: begin
                    // only clock enable is looked at until exit
                    if (bus.cke) begin
                        dev_q <= sdcl_pkg::SDCL_D_NORMAL;                // [RULE_10]
                    end
                end
                default: dev_q <= sdcl_pkg::SDCL_D_NORMAL;
            endcase
        end
    end

    // mode register load
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= sdcl_pkg::MODE_RESET_VAL;
        end else if (dev_q == sdcl_pkg::SDCL_D_NORMAL && bus.cke && !bad
                     && cmd == sdcl_pkg::SDCL_MODE_SET_CMD) begin
            mode_q <= bus.addr;                                          // [RULE_08]
        end
    end

    // internal row counter; address pins play no part
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            refresh_row_q <= '0;
        end else if (dev_q == sdcl_pkg::SDCL_D_NORMAL && bus.cke && !bad
                     && cmd == sdcl_pkg::SDCL_REFRESH_CMD) begin
            refresh_row_q <= refresh_row_q + 1'b1;                       // [RULE_09]
        end
    end

    // per-bank state: write with auto-precharge runs burst then recovery
    for (genvar b = 0; b < 2; b++) begin : g_bank
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                bank_q[b]     <= sdcl_pkg::SDCL_B_IDLE;
                bank_tmr_q[b] <= '0;
            end else if (bank_q[b] == sdcl_pkg::SDCL_B_WRAP) begin
                // deselect, nop and burst stop have no effect during recovery
                if (bank_tmr_q[b] == '0) begin
                    bank_q[b] <= sdcl_pkg::SDCL_B_IDLE;                  // [RULE_01] [RULE_18]
                end else begin
                    bank_tmr_q[b] <= bank_tmr_q[b] - 1'b1;
                end
            end else if (dev_q == sdcl_pkg::SDCL_D_NORMAL && bus.cke && !bad
                         && sel == 1'(b)) begin
                if (cmd == sdcl_pkg::SDCL_ACTIVATE_CMD) begin
                    bank_q[b] <= sdcl_pkg::SDCL_B_ACTIVE;
                end else if (cmd == sdcl_pkg::SDCL_PRECHARGE_CMD) begin
                    bank_q[b] <= sdcl_pkg::SDCL_B_IDLE;
                end else if (cmd == sdcl_pkg::SDCL_WRITE_CMD && bus.addr[10]) begin
                    bank_q[b]     <= sdcl_pkg::SDCL_B_WRAP;
                    bank_tmr_q[b] <= sdcl_pkg::TIMER_W'(BURST_CYC
                                     + sdcl_pkg::WRITE_TO_IDLE_CYC - 1);
                end else if (cmd == sdcl_pkg::SDCL_READ_CMD && bus.addr[10]) begin
                    bank_q[b]     <= sdcl_pkg::SDCL_B_WRAP;
                    bank_tmr_q[b] <= sdcl_pkg::TIMER_W'(BURST_CYC - 1);
                end
            end
        end
        assign bank_idle[b] = bank_q[b] == sdcl_pkg::SDCL_B_IDLE;
    end

    // precharge-all when a10 high closes both non-recovering banks
    // is left to the host issuing one precharge per bank; kept simple

    // registered flag: one cycle after the offending command
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            illegal_q <= 1'b0;
        end else begin
            illegal_q <= bad;
        end
    end


    assign dev_busy     = dev_q == sdcl_pkg::SDCL_D_REFRESH || dev_q == sdcl_pkg::SDCL_D_MODE_SET;
    assign power_down   = dev_q == sdcl_pkg::SDCL_D_POWER_DOWN;
    assign self_refresh = dev_q == sdcl_pkg::SDCL_D_SELF_REFRESH;
endmodule
`default_nettype wire

// ==== rtl/sdcl_host.sv ====
`timescale 1ns/100ps
`default_nettype none
// controller end: takes one request, waits for legality, drives it one cycle
module sdcl_host (
    input  wire logic                 clock,     // system clock
    input  wire logic                 rst_n,     // async reset, active low
    sdcl_if.host                      bus,       // command pins
    input  wire sdcl_pkg::sdcl_cmd_t  req_cmd,   // requested command
    input  wire logic [11:0]          req_addr,  // address incl bank bit
    input  wire logic                 req_valid, // request present
    output logic                      req_ready, // request taken this cycle
    input  wire logic                 sleep_req  // hold cke low when idle
);
    sdcl_pkg::sdcl_bank_t bank_q [2];
    logic [sdcl_pkg::TIMER_W-1:0] col_tmr_q [2];
    logic [sdcl_pkg::TIMER_W-1:0] ras_tmr_q [2];
    logic [sdcl_pkg::TIMER_W-1:0] rrd_tmr_q;
    logic [sdcl_pkg::TIMER_W-1:0] dev_tmr_q;
    logic        sel;
    logic        all_idle;
    logic        ok;

    assign sel      = req_addr[sdcl_pkg::BANK_BIT];
    assign all_idle = bank_q[0] == sdcl_pkg::SDCL_B_IDLE && bank_q[1] == sdcl_pkg::SDCL_B_IDLE;

    // legality of the pending request for the addressed bank
    always_comb begin
        ok = dev_tmr_q == '0 && !sleep_req;                              // [RULE_03] [RULE_04]
        unique case (req_cmd)
            sdcl_pkg::SDCL_ACTIVATE_CMD:
                ok = ok && bank_q[sel] == sdcl_pkg::SDCL_B_IDLE && rrd_tmr_q == '0; // [RULE_11] [RULE_16]
            sdcl_pkg::SDCL_READ_CMD, sdcl_pkg::SDCL_WRITE_CMD:
                ok = ok && bank_q[sel] == sdcl_pkg::SDCL_B_ACTIVE && col_tmr_q[sel] == '0; // [RULE_12] [RULE_19]
            sdcl_pkg::SDCL_PRECHARGE_CMD:
                ok = ok && bank_q[sel] != sdcl_pkg::SDCL_B_WRAP && ras_tmr_q[sel] == '0; // [RULE_02] [RULE_17]
            sdcl_pkg::SDCL_REFRESH_CMD, sdcl_pkg::SDCL_MODE_SET_CMD:
                ok = ok && all_idle;                                     // [RULE_07]
            sdcl_pkg::SDCL_BURST_STOP_CMD:
                ok = 1'b0;                                               // [RULE_13]
            default: ok = 1'b0;
        endcase
    end
    assign req_ready = req_valid && ok;

    // pin drivers: one registered command, deselect otherwise
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'hF;
            bus.addr <= '0;
            bus.cke  <= 1'b1;
        end else begin
            bus.cke  <= !(sleep_req && all_idle && dev_tmr_q == '0);     // [RULE_14]
            bus.addr <= req_addr;
            {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'hF;
            if (req_ready) begin
                unique case (req_cmd)
                    sdcl_pkg::SDCL_READ_CMD:      {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h5;
                    sdcl_pkg::SDCL_WRITE_CMD:     {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h4;
                    sdcl_pkg::SDCL_ACTIVATE_CMD:  {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h3;
                    sdcl_pkg::SDCL_PRECHARGE_CMD: {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h2;
                    sdcl_pkg::SDCL_REFRESH_CMD:   {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h1;
                    sdcl_pkg::SDCL_MODE_SET_CMD:  {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'h0;
                    default:                      {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} <= 4'hF;
                endcase
            end
        end
    end

    // device-wide wait after refresh or mode set, and bank-to-bank activate gap
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dev_tmr_q <= '0;
            rrd_tmr_q <= '0;
        end else begin
            if (req_ready && req_cmd == sdcl_pkg::SDCL_REFRESH_CMD)
                dev_tmr_q <= sdcl_pkg::TIMER_W'(sdcl_pkg::REFRESH_CYCLE_CYC);
            else if (req_ready && req_cmd == sdcl_pkg::SDCL_MODE_SET_CMD)
                dev_tmr_q <= sdcl_pkg::TIMER_W'(sdcl_pkg::MODE_SET_DELAY_CYC);
            else if (dev_tmr_q != '0)
                dev_tmr_q <= dev_tmr_q - 1'b1;
            if (req_ready && req_cmd == sdcl_pkg::SDCL_ACTIVATE_CMD)
                rrd_tmr_q <= sdcl_pkg::TIMER_W'(sdcl_pkg::BANK_TO_BANK_CYC);  // [RULE_16]
            else if (rrd_tmr_q != '0)
                rrd_tmr_q <= rrd_tmr_q - 1'b1;
        end
    end

    // per-bank tracking; auto-precharge treated as worst-case write recovery
    for (genvar b = 0; b < 2; b++) begin : g_bank
        always_ff @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
                bank_q[b]    <= sdcl_pkg::SDCL_B_IDLE;
                col_tmr_q[b] <= '0;
                ras_tmr_q[b] <= '0;
            end else if (req_ready && sel == 1'(b)) begin                // [RULE_20]
                if (req_cmd == sdcl_pkg::SDCL_ACTIVATE_CMD) begin
                    bank_q[b]    <= sdcl_pkg::SDCL_B_ACTIVE;
                    col_tmr_q[b] <= sdcl_pkg::TIMER_W'(sdcl_pkg::ACTIVATE_TO_COLUMN_CYC); // [RULE_19]
                    ras_tmr_q[b] <= sdcl_pkg::TIMER_W'(sdcl_pkg::ACTIVE_TO_PRECHARGE_CYC); // [RULE_17]
                end else if (req_cmd == sdcl_pkg::SDCL_PRECHARGE_CMD) begin
                    bank_q[b] <= sdcl_pkg::SDCL_B_IDLE;
                end else if (req_addr[10] && (req_cmd == sdcl_pkg::SDCL_READ_CMD
                             || req_cmd == sdcl_pkg::SDCL_WRITE_CMD)) begin
                    bank_q[b]    <= sdcl_pkg::SDCL_B_WRAP;                // [RULE_18]
                    col_tmr_q[b] <= sdcl_pkg::TIMER_W'(4 + sdcl_pkg::WRITE_TO_IDLE_CYC);
                end
            end else begin
                if (col_tmr_q[b] != '0) col_tmr_q[b] <= col_tmr_q[b] - 1'b1;
                if (ras_tmr_q[b] != '0) ras_tmr_q[b] <= ras_tmr_q[b] - 1'b1;
                if (bank_q[b] == sdcl_pkg::SDCL_B_WRAP && col_tmr_q[b] == '0)
                    bank_q[b] <= sdcl_pkg::SDCL_B_IDLE;                  // [RULE_01]
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/sdcl_asserts.sv ====
`timescale 1ns/100ps
`default_nettype none
module sdcl_asserts (
    input  wire logic        clock,          // system clock
    input  wire logic        rst_n,          // async reset, active low
    input  wire logic        cs_n,           // chip select
    input  wire logic        ras_n,          // row strobe
    input  wire logic        cas_n,          // column strobe
    input  wire logic        we_n,           // write enable
    input  wire logic        cke,            // clock enable
    input  wire logic [11:0] addr,           // address, bit 11 bank
    input  wire logic [11:0] mode_q,         // operating code
    input  wire logic [10:0] refresh_row_q,  // refresh row counter
    input  wire logic [1:0]  bank_idle,      // per-bank idle
    input  wire logic        dev_busy,       // refresh or mode set running
    input  wire logic        power_down,     // in power-down
    input  wire logic        self_refresh,   // in self-refresh
    input  wire logic        illegal_q       // illegal command flag
);
    // own strobe decode, so a decode slip in the device cannot hide itself
    logic act, rw, ref_c, mode_set_cmd, calm;
    assign act = !cs_n && !ras_n && cas_n && we_n;
    assign rw = !cs_n && ras_n && !cas_n;
    assign ref_c = !cs_n && !ras_n && !cas_n && we_n;
    assign mode_set_cmd = !cs_n && !ras_n && !cas_n && !we_n;
    // normal state with both banks idle: mode set and refresh are legal
    assign calm = cke && bank_idle == 2'h3 && !dev_busy && !power_down && !self_refresh;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    a_mode_load: assert property (mode_set_cmd && calm |=> mode_q == $past(addr))
        else $error("mode register missed the op code");
    a_mode_busy: assert property (mode_set_cmd && calm |=> dev_busy[*2] ##1 !dev_busy)
        else $error("mode set delay wrong");
    a_refresh_busy: assert property (ref_c && calm |=> dev_busy[*8] ##1 dev_busy[*4] ##1 !dev_busy)
        else $error("refresh cycle time wrong");
    a_refresh_row: assert property (ref_c && calm |=> refresh_row_q == $past(refresh_row_q) + 11'h001)
        else $error("refresh row not stepped");
    a_busy_hold: assert property (dev_busy |=> $stable(mode_q) && $stable(bank_idle))
        else $error("state moved while busy");
    a_host_quiet: assert property (dev_busy |-> cs_n)
        else $error("command issued while busy");
    a_act_gap: assert property (act |=> !act)
        else $error("bank to bank activate too close");
    a_act_to_col: assert property (act |=> !(rw && addr[11] == $past(addr[11]))
        ##1 !(rw && addr[11] == $past(addr[11], 2)))
        else $error("column access too soon after activate");
    a_power_down: assert property (!cke && calm == 1'b0 && bank_idle == 2'h3 && !dev_busy
        && !self_refresh && !ref_c |=> power_down)
        else $error("power-down not entered");
    a_no_illegal: assert property (!illegal_q)
        else $error("device saw an illegal command");
endmodule
`default_nettype wire

// ==== verif/sdram_command_legality_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module sdram_command_legality_tb;
    logic                clock, rst_n, req_valid, req_ready, sleep_req;
    sdcl_pkg::sdcl_cmd_t req_cmd;
    logic [11:0]         req_addr, mode_q;
    logic [10:0]         refresh_row_q;
    logic [1:0]          bank_idle;
    logic                dev_busy, power_down, self_refresh, illegal_q;
    int                  err_total, n_tests;
    sdcl_if sdcl_if_i ();
    sdcl_device #(.BURST_CYC(4)) sdcl_device_i (.clock(clock), .rst_n(rst_n), .bus(sdcl_if_i),
        .mode_q(mode_q), .refresh_row_q(refresh_row_q), .bank_idle(bank_idle),
        .dev_busy(dev_busy), .power_down(power_down), .self_refresh(self_refresh),
        .illegal_q(illegal_q));
    sdcl_host sdcl_host_i (.clock(clock), .rst_n(rst_n), .bus(sdcl_if_i), .req_cmd(req_cmd),
        .req_addr(req_addr), .req_valid(req_valid), .req_ready(req_ready),
        .sleep_req(sleep_req));
    sdcl_asserts sdcl_asserts_i (.clock(clock), .rst_n(rst_n), .cs_n(sdcl_if_i.cs_n),
        .ras_n(sdcl_if_i.ras_n), .cas_n(sdcl_if_i.cas_n), .we_n(sdcl_if_i.we_n),
        .cke(sdcl_if_i.cke), .addr(sdcl_if_i.addr), .mode_q(mode_q),
        .refresh_row_q(refresh_row_q), .bank_idle(bank_idle), .dev_busy(dev_busy),
        .power_down(power_down), .self_refresh(self_refresh), .illegal_q(illegal_q));
    // 200 MHz system clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // hold the request until ready is seen just before a rising edge
    task automatic issue(input sdcl_pkg::sdcl_cmd_t c, input logic [11:0] a);
        int n;
        n = 0;
        @(negedge clock);
        req_cmd = c;
        req_addr = a;
        req_valid = 1'b1;
        #2;
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge clock);
            #2;
            n++;
        end
        chk("request taken", 12'h001, {11'h000, req_ready});
        @(negedge clock);
        req_valid = 1'b0;
    endtask
    // strobes on the wire now, as cs ras cas we, then one cycle on
    task automatic pins(input logic [3:0] exp);
        chk("strobes", {8'h00, exp}, {8'h00, sdcl_if_i.cs_n, sdcl_if_i.ras_n,
            sdcl_if_i.cas_n, sdcl_if_i.we_n});
        @(negedge clock);
    endtask
    // a refused request must not see ready in 20 cycles
    task automatic refused(input sdcl_pkg::sdcl_cmd_t c);
        logic seen;
        seen = 1'b0;
        @(negedge clock);
        req_cmd = c;
        req_valid = 1'b1;
        repeat (20) begin
            #2;
            seen = seen | (req_ready !== 1'b0);
            @(negedge clock);
        end
        req_valid = 1'b0;
        chk("refused", 12'h000, {11'h000, seen});
    endtask
    task automatic busy_len(output int n);
        int w;
        w = 0;
        n = 0;
        while (dev_busy !== 1'b1 && w < 10) begin
            @(negedge clock);
            w++;
        end
        while (dev_busy === 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
    endtask
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // watchdog, far beyond the hundred or so cycles the sequence needs
    initial begin
        repeat (5000) @(posedge clock);
        err_total++;
        end_of_test();
    end
    initial begin
        int          n;
        logic [10:0] row;
        err_total = 0;
        n_tests = 0;
        rst_n = 1'b0;
        req_valid = 1'b0;
        req_cmd = sdcl_pkg::SDCL_NOP_CMD;
        req_addr = 12'h000;
        sleep_req = 1'b0;
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        chk("bank idle", 12'h003, {10'h000, bank_idle});
        chk("mode", sdcl_pkg::MODE_RESET_VAL, mode_q);
        // mode set: op code loaded, busy for the delay
        issue(sdcl_pkg::SDCL_MODE_SET_CMD, 12'h027);
        pins(4'h0);
        busy_len(n);
        chk("mode", 12'h027, mode_q);
        chk("mode busy", 12'(sdcl_pkg::MODE_SET_DELAY_CYC), 12'(n));
        // refresh ignores the address, steps its own row
        row = refresh_row_q;
        issue(sdcl_pkg::SDCL_REFRESH_CMD, 12'hFFF);
        pins(4'h1);
        busy_len(n);
        chk("refresh busy", 12'(sdcl_pkg::REFRESH_CYCLE_CYC), 12'(n));
        chk("row", {1'b0, row + 11'h001}, {1'b0, refresh_row_q});
        chk("mode", 12'h027, mode_q);
        // both banks opened in turn with a deselect between, then write with auto-precharge
        issue(sdcl_pkg::SDCL_ACTIVATE_CMD, 12'h005);
        pins(4'h3);
        pins(4'hF);
        issue(sdcl_pkg::SDCL_ACTIVATE_CMD, 12'h805);
        issue(sdcl_pkg::SDCL_WRITE_CMD, 12'hC00);
        pins(4'h4);
        chk("bank idle", 12'h000, {10'h000, bank_idle});
        n = 0;
        while (bank_idle[1] !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        chk("recovery", 12'(4 + sdcl_pkg::WRITE_TO_IDLE_CYC), 12'(n));
        // read then precharge on the bank still open
        issue(sdcl_pkg::SDCL_READ_CMD, 12'h010);
        pins(4'h5);
        issue(sdcl_pkg::SDCL_PRECHARGE_CMD, 12'h000);
        pins(4'h2);
        repeat (2) @(negedge clock);
        chk("bank idle", 12'h003, {10'h000, bank_idle});
        // full page burst; the host still never sends burst stop
        issue(sdcl_pkg::SDCL_MODE_SET_CMD, 12'h007);
        refused(sdcl_pkg::SDCL_BURST_STOP_CMD);
        chk("mode", 12'h007, mode_q);
        // sleep with both banks idle, then wake and refresh
        sleep_req = 1'b1;
        repeat (4) @(negedge clock);
        chk("cke", 12'h000, {11'h000, sdcl_if_i.cke});
        chk("power down", 12'h001, {11'h000, power_down});
        chk("self refresh", 12'h000, {11'h000, self_refresh});
        sleep_req = 1'b0;
        repeat (4) @(negedge clock);
        chk("power down", 12'h000, {11'h000, power_down});
        issue(sdcl_pkg::SDCL_REFRESH_CMD, 12'h000);
        busy_len(n);
        chk("refresh busy", 12'(sdcl_pkg::REFRESH_CYCLE_CYC), 12'(n));
        end_of_test();
    end
endmodule
`default_nettype wire
